// ===== core/ipas_ahb_slave.v
// ahb-lite slave front end: zero-wait writes, one-wait registered reads
`timescale 1ns/1ps
`default_nettype none
`include "ipas_defines.vh"

module ipas_ahb_slave (
  // clock, reset, freeze
  input  wire                     hclk,
  input  wire                     hresetn,
  input  wire                     ce,
  // ahb-lite bus
  input  wire                     hsel,
  input  wire [`IPAS_ADDR_W-1:0]  haddr,
  input  wire [1:0]               htrans,
  input  wire                     hwrite,
  input  wire [2:0]               hsize,
  input  wire [3:0]               hprot,
  input  wire [`IPAS_DATA_W-1:0]  hwdata,
  input  wire                     hready,
  output wire                     hreadyout,
  output wire                     hresp,
  output reg  [`IPAS_DATA_W-1:0]  hrdata,
  // register side
  output wire                     wr_en,
  output wire [`IPAS_ADDR_W-1:0]  reg_addr,
  output wire [`IPAS_DATA_W-1:0]  wr_data,
  input  wire [`IPAS_DATA_W-1:0]  rd_data,
  output wire                     priv_fault
);

  // ----------------------------------------------------------------------------
  // one-hot data-phase states
  // ----------------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_WR   = 3'h2;
  localparam [2:0] S_RD   = 3'h4;

  reg [2:0]              state;
  reg [`IPAS_ADDR_W-1:0] addr_q;
  reg                    priv_q;
  wire                   take;

  // an address phase is taken on nonseq/seq while the bus is ready
  assign take = hsel & hready & htrans[1];

  // address latch and data-phase sequencing
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state  <= S_IDLE;
      addr_q <= {`IPAS_ADDR_W{1'b0}};
      priv_q <= 1'b0;
      hrdata <= {`IPAS_DATA_W{1'b0}};
    end else if (ce) begin
      case (state)
        S_IDLE, S_WR: begin
          if (take) begin
            addr_q <= haddr;
            priv_q <= hprot[1];
            state  <= hwrite ? S_WR : S_RD;
          end else begin
            state <= S_IDLE;
          end
        end
        S_RD: begin
          hrdata <= priv_q ? rd_data : {`IPAS_DATA_W{1'b0}};
          state  <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // reads stall one cycle so a preceding write has landed before sampling
  assign hreadyout  = (state != S_RD);
  assign hresp      = 1'b0;
  assign reg_addr   = addr_q;
  assign wr_data    = hwdata;
  // unprivileged writes never reach the banks
  assign wr_en      = ce & state[1] & priv_q;
  assign priv_fault = ce & ~priv_q & (state[1] | state[2]);

endmodule
`default_nettype wire

// ===== core/ipas_defines.vh
// register map, field layout, reset values and sizes of the pending/active store
`ifndef IPAS_DEFINES_VH
`define IPAS_DEFINES_VH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define IPAS_NUM_IRQ      200
`define IPAS_ADDR_W       12
`define IPAS_DATA_W       32

// ----------------------------------------------------------------------------
// bank and register byte offsets
// ----------------------------------------------------------------------------
`define IPAS_SET_BANK_OFS 12'h200
`define IPAS_CLR_BANK_OFS 12'h280
`define IPAS_ACT_BANK_OFS 12'h300
`define IPAS_EVT_STAT_OFS 12'h380
`define IPAS_EVT_MASK_OFS 12'h384

// ----------------------------------------------------------------------------
// event status / mask fields
// ----------------------------------------------------------------------------
`define IPAS_EVT_W        3
`define IPAS_EVT_NEWPEND  0
`define IPAS_EVT_ACTREF   1
`define IPAS_EVT_PRIVREF  2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define IPAS_BANK_RST     32'h0000_0000
`define IPAS_EVT_RST      3'h0

`endif

// ===== core/ipas_evt_flags.v
// sticky event flags with write-one-to-clear, mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ipas_defines.vh"

module ipas_evt_flags #(
  parameter W = `IPAS_EVT_W
) (
  // clock, reset, freeze
  input  wire         hclk,
  input  wire         hresetn,
  input  wire         ce,
  // events and software access
  input  wire [W-1:0] evt,
  input  wire         clr_we,
  input  wire         mask_we,
  input  wire [W-1:0] wdata,
  // state and interrupt
  output reg  [W-1:0] status,
  output reg  [W-1:0] mask,
  output wire         irq
);

  // set wins over a clear landing in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= {W{1'b0}};
      mask   <= {W{1'b0}};
    end else if (ce) begin
      status <= (status & ~(clr_we ? wdata : {W{1'b0}})) | evt;
      if (mask_we) begin
        mask <= wdata;
      end
    end
  end

  assign irq = |(status & mask);

endmodule
`default_nettype wire

// ===== core/ipas_top.v
// pending and active state store for 200 interrupt lines behind ahb-lite
// ----------------------------------------------------------------------------
// Summary of operation
// - word k bit b is interrupt 32k+b; word 6 holds interrupts 192 to 199
// - writing one to a set-pending bit makes that interrupt pending, even disabled
// - setting an already pending interrupt changes nothing
// - zeros written to set or clear banks have no effect
// - set and clear banks both read back the pending state
// - pending bits clear only by a one in the clear bank or by an accepted activation
// - a one in the clear bank removes pending state
// - clearing pending leaves active state alone
// - active bank is read-only and shows active state regardless of pending
// - banks act on privileged accesses only; unprivileged reads give zero, writes drop
// - banks sit at 0x200, 0x280 and 0x300, one word per four bytes
// - reset clears all pending and active bits
// - a line edge pends; only pending enabled interrupts may activate
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "ipas_defines.vh"

module ipas_top #(
  parameter NUM_IRQ = `IPAS_NUM_IRQ
) (
  // clock, reset, freeze
  input  wire                     hclk,
  input  wire                     hresetn,
  input  wire                     ce,
  // ahb-lite bus
  input  wire                     hsel,
  input  wire [`IPAS_ADDR_W-1:0]  haddr,
  input  wire [1:0]               htrans,
  input  wire                     hwrite,
  input  wire [2:0]               hsize,
  input  wire [3:0]               hprot,
  input  wire [`IPAS_DATA_W-1:0]  hwdata,
  input  wire                     hready,
  output wire                     hreadyout,
  output wire                     hresp,
  output wire [`IPAS_DATA_W-1:0]  hrdata,
  // peripheral request lines and enables
  input  wire [NUM_IRQ-1:0]       irq_line,
  input  wire [NUM_IRQ-1:0]       irq_enable,
  // activation and completion from the exception logic
  input  wire                     act_valid,
  input  wire [7:0]               act_num,
  output wire                     act_accept,
  input  wire                     done_valid,
  input  wire [7:0]               done_num,
  // state towards prioritisation
  output reg  [NUM_IRQ-1:0]       irq_pending,
  output reg  [NUM_IRQ-1:0]       irq_active,
  // event interrupt
  output wire                     evt_irq
);

  // ----------------------------------------------------------------------------
  // behaviour at the ports
  // ----------------------------------------------------------------------------
  // writes land at the edge ending their data phase, no wait state
  // reads stall one cycle, so a read after a write sees it
  // unprivileged accesses answer okay: writes drop, reads give zero
  // words past the last interrupt read zero and ignore writes
  // a line edge or a set-bank one beats a clear in one cycle
  // accept is combinational, seen in the request cycle
  // an accepted activation moves pending to active at one edge
  // activation beats a completion of the same interrupt
  // pending and active leave as registered levels
  // event flags: new pending, refused activation, refused access
  // with ce low every register holds and no strobe is raised

  // ----------------------------------------------------------------------------
  // sizes and decode constants
  // ----------------------------------------------------------------------------
  localparam integer WORDS = (NUM_IRQ + 31) / 32;
  localparam integer PAD_W = WORDS * 32;
  localparam [`IPAS_ADDR_W-1:0] SET_OFS  = `IPAS_SET_BANK_OFS;
  localparam [`IPAS_ADDR_W-1:0] CLR_OFS  = `IPAS_CLR_BANK_OFS;
  localparam [`IPAS_ADDR_W-1:0] ACT_OFS  = `IPAS_ACT_BANK_OFS;
  localparam [`IPAS_ADDR_W-1:0] STAT_OFS = `IPAS_EVT_STAT_OFS;
  localparam [`IPAS_ADDR_W-1:0] MASK_OFS = `IPAS_EVT_MASK_OFS;
  // word count cut to the width of the word index
  localparam [2:0]              WORDS_W  = WORDS[2:0];

  // ----------------------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------------------
  wire                    wr_en;
  wire [`IPAS_ADDR_W-1:0] reg_addr;
  wire [`IPAS_DATA_W-1:0] wr_data;
  reg  [`IPAS_DATA_W-1:0] rd_data;
  wire                    priv_fault;

  // zero-wait writes, one-wait reads; unprivileged accesses are dropped
  ipas_ahb_slave u_bus (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .hsel       (hsel),
    .haddr      (haddr),
    .htrans     (htrans),
    .hwrite     (hwrite),
    .hsize      (hsize),
    .hprot      (hprot),
    .hwdata     (hwdata),
    .hready     (hready),
    .hreadyout  (hreadyout),
    .hresp      (hresp),
    .hrdata     (hrdata),
    .wr_en      (wr_en),
    .reg_addr   (reg_addr),
    .wr_data    (wr_data),
    .rd_data    (rd_data),
    .priv_fault (priv_fault)
  );

  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------
  wire [2:0] word;
  wire       word_ok;
  wire       base_set;
  wire       base_clr;
  wire       base_act;
  wire       hit_stat;
  wire       hit_mask;
  wire       in_set;
  wire       in_clr;
  wire       in_act;
  wire       wr_set;
  wire       wr_clr;
  wire       wr_stat;
  wire       wr_mask;

  // each bank spans 32 bytes; word index in bits 4:2
  assign word     = reg_addr[4:2];
  assign word_ok  = (word < WORDS_W);
  // bank base match on the bits above the word index
  assign base_set = (reg_addr[11:5] == SET_OFS[11:5]);
  assign base_clr = (reg_addr[11:5] == CLR_OFS[11:5]);
  assign base_act = (reg_addr[11:5] == ACT_OFS[11:5]);
  // the event registers decode on the full address
  assign hit_stat = (reg_addr == STAT_OFS);
  assign hit_mask = (reg_addr == MASK_OFS);
  // a word past the last one is unmapped in every bank
  assign in_set   = base_set & word_ok;
  assign in_clr   = base_clr & word_ok;
  assign in_act   = base_act & word_ok;
  // write strobes; the active bank has none, so its writes are dropped
  assign wr_set   = wr_en & in_set;
  assign wr_clr   = wr_en & in_clr;
  assign wr_stat  = wr_en & hit_stat;
  assign wr_mask  = wr_en & hit_mask;

  // ----------------------------------------------------------------------------
  // per-interrupt pending and active state
  // ----------------------------------------------------------------------------
  reg  [NUM_IRQ-1:0] line_q;
  wire [NUM_IRQ-1:0] sw_set;
  wire [NUM_IRQ-1:0] sw_clr;
  wire [NUM_IRQ-1:0] line_rise;
  wire [NUM_IRQ-1:0] act_hit;
  wire [NUM_IRQ-1:0] done_hit;
  wire [NUM_IRQ-1:0] next_pending;
  wire [NUM_IRQ-1:0] next_active;

  genvar i;
  generate
    for (i = 0; i < NUM_IRQ; i = i + 1) begin : g_irq
      localparam integer WIDX_I = i / 32;
      localparam integer NUM_I  = i;
      localparam [2:0]   WIDX   = WIDX_I[2:0];
      localparam [7:0]   NUM    = NUM_I[7:0];
      wire               word_hit;
      wire               wbit;
      wire               act_sel;
      wire               done_sel;
      // this interrupt's word is addressed; its bit of the written word
      assign word_hit     = (word == WIDX);
      assign wbit         = wr_data[i % 32];
      // a one in the matching word and bit sets or clears; a zero does nothing
      assign sw_set[i]    = wr_set & word_hit & wbit;
      assign sw_clr[i]    = wr_clr & word_hit & wbit;
      assign line_rise[i] = irq_line[i] & ~line_q[i];
      // activation and completion requests aimed at this interrupt
      assign act_sel      = act_valid & (act_num == NUM);
      assign done_sel     = done_valid & (done_num == NUM);
      // disabled or idle interrupts are never activated
      assign act_hit[i]   = act_sel & irq_pending[i] & irq_enable[i];
      assign done_hit[i]  = done_sel;
      // set sources win over clears in the same cycle; set-bank never clears
      assign next_pending[i] = (irq_pending[i] & ~(sw_clr[i] | act_hit[i]))
                               | sw_set[i] | line_rise[i];
      // clear bank has no term here
      assign next_active[i]  = (irq_active[i] & ~done_hit[i])
                               | act_hit[i];
    end
  endgenerate

  // pending and active state, all cleared at reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_pending <= {NUM_IRQ{1'b0}};
      irq_active  <= {NUM_IRQ{1'b0}};
    end else if (ce) begin
      irq_pending <= next_pending;
      irq_active  <= next_active;
    end
  end

  // last sampled line level; zero after reset, so a line high at release pends
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_q <= {NUM_IRQ{1'b0}};
    end else if (ce) begin
      line_q <= irq_line;
    end
  end

  // ----------------------------------------------------------------------------
  // activation handshake
  // ----------------------------------------------------------------------------
  // accept is combinational so the requester sees it in the request cycle
  assign act_accept = ce & (|act_hit);

  // ----------------------------------------------------------------------------
  // event flags and interrupt
  // ----------------------------------------------------------------------------
  wire [`IPAS_EVT_W-1:0] evt;
  wire [`IPAS_EVT_W-1:0] evt_status;
  wire [`IPAS_EVT_W-1:0] evt_mask;

  wire                   new_irq_set_waiting_bank;
  wire                   act_refused;

  // some interrupt leaves the idle state in this cycle
  assign new_irq_set_waiting_bank    = |((sw_set | line_rise) & ~irq_pending);
  // an activation request that names no pending enabled interrupt
  assign act_refused = act_valid & ~(|act_hit);

  // new pending, refused activation, refused unprivileged access
  assign evt[`IPAS_EVT_NEWPEND] = ce & new_irq_set_waiting_bank;
  assign evt[`IPAS_EVT_ACTREF]  = ce & act_refused;
  assign evt[`IPAS_EVT_PRIVREF] = priv_fault;

  // sticky event flags, one to clear, a set in the same cycle wins
  ipas_evt_flags #(
    .W (`IPAS_EVT_W)
  ) u_evt (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .evt     (evt),
    .clr_we  (wr_stat),
    .mask_we (wr_mask),
    .wdata   (wr_data[`IPAS_EVT_W-1:0]),
    .status  (evt_status),
    .mask    (evt_mask),
    .irq     (evt_irq)
  );

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  wire [PAD_W-1:0]        irq_set_waiting_bank_pad;
  wire [PAD_W-1:0]        act_pad;
  wire [`IPAS_DATA_W-1:0] irq_set_waiting_bank_word [0:WORDS-1];
  wire [`IPAS_DATA_W-1:0] act_word  [0:WORDS-1];
  wire [`IPAS_DATA_W-1:0] stat_word;
  wire [`IPAS_DATA_W-1:0] mask_word;

  // unused upper bits of the last word read as zero
  assign irq_set_waiting_bank_pad = {{(PAD_W-NUM_IRQ){1'b0}}, irq_pending};
  assign act_pad  = {{(PAD_W-NUM_IRQ){1'b0}}, irq_active};

  // one read view per bank word
  genvar k;
  generate
    for (k = 0; k < WORDS; k = k + 1) begin : g_word
      assign irq_set_waiting_bank_word[k] = irq_set_waiting_bank_pad[k*32 +: 32];
      assign act_word[k]  = act_pad[k*32 +: 32];
    end
  endgenerate

  // event registers widened to a bus word
  assign stat_word = {{(`IPAS_DATA_W-`IPAS_EVT_W){1'b0}}, evt_status};
  assign mask_word = {{(`IPAS_DATA_W-`IPAS_EVT_W){1'b0}}, evt_mask};

  // unmapped addresses read as zero
  always @* begin
    rd_data = `IPAS_BANK_RST;
    if (in_set | in_clr) begin
      rd_data = irq_set_waiting_bank_word[word];
    end else if (in_act) begin
      rd_data = act_word[word];
    end else if (hit_stat) begin
      rd_data = stat_word;
    end else if (hit_mask) begin
      rd_data = mask_word;
    end
  end

endmodule
`default_nettype wire

// ===== test/ipas_checker.sv
// port assertions for the pending and active store
`timescale 1ns/1ps
`default_nettype none
module ipas_checker #(
  parameter NUM_IRQ = 200
) (
  // clock, reset, freeze
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               ce,
  // bus
  input wire logic               hsel,
  input wire logic [11:0]        haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // interrupt state
  input wire logic [NUM_IRQ-1:0] irq_line,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic [NUM_IRQ-1:0] irq_pending,
  input wire logic [NUM_IRQ-1:0] irq_active,
  input wire logic               act_valid,
  input wire logic [7:0]         act_num,
  input wire logic               act_accept,
  input wire logic               done_valid
);
  // ----------------------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------------------
  logic [NUM_IRQ-1:0] line_q;
  logic               clr_ph;
  // last line level and a taken write aimed at the clear bank
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_q <= '0;
      clr_ph <= 1'b0;
    end else if (ce) begin
      line_q <= irq_line;
      clr_ph <= hsel && hready && htrans[1] && hwrite && haddr[11:7] == 5'h05;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_taken;
    hsel && hready && htrans[1] && !hwrite && ce;
  endsequence
  sequence wr_taken;
    hsel && hready && htrans[1] && hwrite && ce;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  a_write_nowait: assert property (wr_taken |=> hreadyout)
    else $error("write data phase stalled");
  a_accept_cause: assert property (act_accept |-> act_valid && act_num < NUM_IRQ
    && irq_pending[act_num] && irq_enable[act_num])
    else $error("activation accepted without pending enabled interrupt");
  a_act_moves: assert property (act_accept
    |=> irq_active[$past(act_num)] && !irq_pending[$past(act_num)])
    else $error("activation did not move pending to active");
  a_active_rise: assert property (|(irq_active & ~$past(irq_active))
    |-> $past(act_accept))
    else $error("active bit set without activation");
  a_active_fall: assert property (|(~irq_active & $past(irq_active))
    |-> $past(done_valid))
    else $error("active bit cleared without completion");
  a_irq_set_waiting_bank_drop: assert property (|(~irq_pending & $past(irq_pending))
    |-> $past(clr_ph) || $past(act_accept))
    else $error("pending bit cleared without cause");
  a_line_pends: assert property (ce && |(irq_line & ~line_q)
    |=> (irq_pending & $past(irq_line & ~line_q)) == $past(irq_line & ~line_q))
    else $error("line edge did not make interrupt pending");
endmodule

bind ipas_top ipas_checker #(.NUM_IRQ(NUM_IRQ)) u_chk (
  .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .irq_line, .irq_enable, .irq_pending, .irq_active, .act_valid, .act_num, .act_accept,
  .done_valid
);
`default_nettype wire

// ===== test/ipas_exc_model.sv
// exception-side model: request lines, enables, activation and completion
`timescale 1ns/1ps
`default_nettype none
module ipas_exc_model #(
  parameter NUM_IRQ = 200
) (
  // clock
  input  wire logic               hclk,
  // request lines and enables
  output var  logic [NUM_IRQ-1:0] irq_line,
  output var  logic [NUM_IRQ-1:0] irq_enable,
  // activation and completion
  output var  logic               act_valid,
  output var  logic [7:0]         act_num,
  input  wire logic               act_accept,
  output var  logic               done_valid,
  output var  logic [7:0]         done_num
);
  // ----------------------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------------------
  // idle levels at time zero
  initial begin
    irq_line = '0;
    irq_enable = '0;
    act_valid = 1'b0;
    act_num = 8'hff;
    done_valid = 1'b0;
    done_num = 8'hff;
  end
  // one activation request, answer read before its edge; only this sets active
  task automatic activate(input logic [7:0] n, output logic acc);
    begin
      @(posedge hclk);
      act_valid <= 1'b1;
      act_num <= n;
      @(negedge hclk);
      acc = act_accept;
      @(posedge hclk);
      act_valid <= 1'b0;
      act_num <= ~n;
    end
  endtask
  // completion of an active interrupt
  task automatic complete(input logic [7:0] n);
    begin
      @(posedge hclk);
      done_valid <= 1'b1;
      done_num <= n;
      @(posedge hclk);
      done_valid <= 1'b0;
      done_num <= ~n;
    end
  endtask
  // enable state of one interrupt, changed just after an edge
  task automatic set_enable(input int n, input logic v);
    begin
      @(posedge hclk);
      irq_enable[n] <= v;
    end
  endtask
  // one rising edge on a request line
  task automatic pulse(input int n);
    begin
      @(posedge hclk);
      irq_line[n] <= 1'b1;
      @(posedge hclk);
      irq_line[n] <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== test/irq_pending_active_state_test.sv
// self-checking bench for the pending and active store
`timescale 1ns/1ps
`default_nettype none
module irq_pending_active_state_test;
  logic         hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, evt_irq, acc;
  logic         act_valid, act_accept, done_valid;
  logic [11:0]  haddr;
  logic [1:0]   htrans;
  logic [3:0]   hprot;
  logic [31:0]  hwdata, hrdata, rd_v;
  logic [7:0]   act_num, done_num;
  logic [199:0] irq_line, irq_enable, irq_pending, irq_active;
  int           err_count, cmp_count;
  // ----------------------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------------------
  ipas_top uut (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hprot,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq_line, .irq_enable,
    .act_valid, .act_num, .act_accept, .done_valid, .done_num, .irq_pending, .irq_active,
    .evt_irq
  );
  ipas_exc_model pm (
    .hclk, .irq_line, .irq_enable, .act_valid, .act_num, .act_accept, .done_valid, .done_num
  );
  // free-running clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count++;
      if (seen !== exp) begin
        err_count++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // pass the next edge at which hready is high; data is taken there
  task automatic step;
    begin
      @(negedge hclk);
      while (hreadyout !== 1'b1) @(negedge hclk);
      rd_v = hrdata;
      @(posedge hclk);
    end
  endtask
  // one single transfer; p is the privilege bit
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic p);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hprot <= {2'h0, p, 1'b1};
      step;
      htrans <= 2'h0;
      hwdata <= d;
      step;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 1'b1);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0, 1'b1);
      chk(rd_v, exp);
    end
  endtask
  task automatic close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #200000;
    err_count++;
    close_out;
  end
  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 12'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hprot = 4'h3;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 21; k++) begin
      rdc(12'h200 + 12'(k / 7) * 12'h80 + 12'(4 * (k % 7)), 32'h0);
    end
    wr(12'h384, 32'h7);
    for (int k = 0; k < 7; k++) wr(12'h200 + 12'(4 * k), 32'h8000_0081);
    for (int k = 0; k < 7; k++) begin
      rdc(12'h200 + 12'(4 * k), k == 6 ? 32'h81 : 32'h8000_0081);
      rdc(12'h280 + 12'(4 * k), k == 6 ? 32'h81 : 32'h8000_0081);
    end
    chk(32'(irq_pending[199:192]), 32'h81);
    chk(32'(evt_irq), 32'h1);
    wr(12'h380, 32'h7);
    @(negedge hclk);
    chk(32'(evt_irq), 32'h0);
    wr(12'h200, 32'h8000_0081);
    wr(12'h200, 32'h0);
    wr(12'h280, 32'h0);
    rdc(12'h200, 32'h8000_0081);
    wr(12'h280, 32'h1);
    rdc(12'h200, 32'h8000_0080);
    pm.activate(8'd32, acc);
    chk(32'(acc), 32'h0);
    pm.set_enable(31, 1'b1);
    pm.activate(8'd31, acc);
    chk(32'(acc), 32'h1);
    rdc(12'h300, 32'h8000_0000);
    rdc(12'h200, 32'h0000_0080);
    pm.pulse(31);
    rdc(12'h280, 32'h8000_0080);
    rdc(12'h300, 32'h8000_0000);
    wr(12'h280, 32'h8000_0000);
    rdc(12'h300, 32'h8000_0000);
    wr(12'h300, 32'h0000_ffff);
    rdc(12'h300, 32'h8000_0000);
    pm.complete(8'd31);
    rdc(12'h300, 32'h0);
    xfer(1'b1, 12'h204, 32'h2, 1'b0);
    xfer(1'b0, 12'h200, 32'h0, 1'b0);
    chk(rd_v, 32'h0);
    rdc(12'h204, 32'h8000_0081);
    rdc(12'h21c, 32'h0);
    // a line edge while ce is low must be lost, not irq_set_waiting_bank
    ce <= 1'b0;
    pm.pulse(40);
    ce <= 1'b1;
    rdc(12'h204, 32'h8000_0081);
    rdc(12'h380, 32'h7);
    chk(32'(evt_irq), 32'h1);
    close_out;
  end
endmodule
`default_nettype wire
